//--- src/rett_pkg.sv
// Package: register map, field layout and constants of the event timer
package rett_pkg;
   // Register indices on the plain register port
   localparam logic [5:0] REG_IRQ_EN      = 6'h06; // interrupt_enable_mask
   localparam logic [5:0] REG_IRQ_RQ      = 6'h07; // interrupt_request_flags
   localparam logic [5:0] REG_CONTROL     = 6'h09; // start/stop commands
   localparam logic [5:0] REG_TIMER_VALUE = 6'h0C; // current_count
   localparam logic [5:0] REG_SEC_STATUS  = 6'h05; // counter_active_flag
   localparam logic [5:0] REG_TIMER_CLOCK = 6'h2A; // exponent, auto reload
   localparam logic [5:0] REG_TIMER_CTRL  = 6'h2B; // start/stop enables
   localparam logic [5:0] REG_RELOAD      = 6'h2C; // reload_register
   localparam logic [5:0] REG_SLOT_LOW    = 6'h3D; // slot interval low byte
   localparam logic [5:0] REG_SIG_OUT_SEL = 6'h3E; // slot interval msb
   localparam logic [5:0] REG_CODER_RATE  = 6'h3F; // encoder_rate_select
   // Field positions
   localparam int BIT_SET_SELECT   = 7; // set/clear select in irq regs
   localparam int BIT_TIMER_IRQ    = 5; // expiry flag and enable
   localparam int BIT_START_NOW    = 1; // in control register
   localparam int BIT_STOP_NOW     = 2; // in control register
   localparam int BIT_RUNNING      = 7; // in secondary status
   localparam int BIT_AUTO_RELOAD  = 5; // in timer clock register
   localparam int BIT_START_TXB    = 0; // timer control bits
   localparam int BIT_START_TXE    = 1;
   localparam int BIT_STOP_RXB     = 2;
   localparam int BIT_STOP_RXE     = 3;
   localparam int BIT_SLOT_MSB     = 7; // in signal output select
   localparam int EXP_W            = 5; // exponent field width
   localparam int SLOT_W           = 9; // slot interval width
   localparam int DIV_W            = 22;
   localparam logic [4:0] EXP_MAX  = 5'h15; // largest legal exponent
   localparam logic [7:0] IRQ_USED = 8'h3F; // implemented request bits
   localparam logic [7:0] ZERO8    = 8'h00;
   localparam logic [7:0] ONE8     = 8'h01;
   localparam logic [7:0] CODER_RESET = 8'h05;
endpackage : rett_pkg

//--- src/rett_timer.sv
// Event timer with auto reload and time slot send trigger
// Function
// RULE_01: Tick is clock over two-power exponent, 0..21
// RULE_02: Count decrements per tick while nonzero, running
// RULE_03: Auto reload loads reload value after one
// RULE_04: Start on tx begin/end, wrap, command
// RULE_05: Every start loads counter from reload register
// RULE_06: Stop on receive begin or end if enabled
// RULE_07: Stop at zero without reload, or command
// RULE_08: Reload write never touches running counter
// RULE_09: Software stop raises no expiry flag
// RULE_10: Active flag follows start and stop events
// RULE_11: Current count readable at any time
// RULE_12: Expiry influences no other operation
// RULE_13: Running out sets request; stop first none
// RULE_14: Slot counter starts at command transmit end
// RULE_15: Slot expiry sends queued FIFO data only
// RULE_16: Slot counter restarts itself on each expiry
// RULE_17: Slot counter counts coder clock cycles
// RULE_18: Zero slot interval never triggers sending
// RULE_19: New slot interval applies at next restart
// RULE_20: Slot interval is nine bits, msb elsewhere
// RULE_21: Software clears checksum enable before slot frames
// RULE_22: Request set on step from one down
// RULE_23: Irq writes change only bits written one
// RULE_24: Start wins over simultaneous stop
// RULE_25: Commands and events acted on exactly once
`timescale 1ns/1ps
module rett_timer
   import rett_pkg::*;
(
   input  wire logic       MCLK,
   input  wire logic       RST,
   input  wire logic [5:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   input  wire logic       TX_BEGIN,
   input  wire logic       TX_END,
   input  wire logic       RX_BEGIN,
   input  wire logic       RX_END,
   input  wire logic       CODER_CLK_EN,
   input  wire logic       FIFO_NOT_EMPTY,
   output logic [7:0]      RDATA,
   output logic            SLOT_SEND,
   output logic            TIMER_IRQ
);
   // All state in one record
   // One packed record holds every flip-flop of the block, so the reset
   // branch clears all of it at once and no field can be forgotten.
   // The coder rate is the only field with a nonzero reset value.
   typedef struct packed {
      logic [7:0]       rdata;      // read answer
      logic [7:0]       irq_en;     // interrupt_enable_mask
      logic [7:0]       irq_rq;     // interrupt_request_flags
      logic [EXP_W-1:0] exp;        // tick_divider_exponent
      logic             auto_rl;    // auto_reload_enable
      logic [3:0]       tctrl;      // start/stop enables
      logic [7:0]       reload;     // reload_register
      logic [7:0]       count;      // current_count
      logic             running;    // counter_active_flag
      logic [DIV_W-1:0] div;        // prescaler
      logic             start_cmd;  // pending immediate start
      logic             stop_cmd;   // pending immediate stop
      logic [3:0]       ev_prev;    // event edge memory
      logic [SLOT_W-1:0] slot_val;  // slot_interval_value
      logic [SLOT_W-1:0] slot_cnt;  // slot counter
      logic             slot_act;   // slot counter running
      logic [7:0]       coder;      // encoder_rate_select
      logic             send;       // send trigger
      logic             irq_out;    // timer irq pin
   } rett_state_t;

   // Registered state and its next value
   rett_state_t s_q, s_d;
   // Helpers below are decided from the registered state and the inputs
   logic [DIV_W-1:0] div_mask;  // prescaler terminal mask
   logic [3:0]       ev_now;    // event inputs
   logic [3:0]       ev_rise;   // one pulse per event
   logic             tick;      // timer clock tick
   logic             start_ev;  // any configured start
   logic             stop_ev;   // any configured stop
   logic             wrap;      // auto reload wrap
   logic             expire;    // count reaches zero
   logic [7:0]       wmask;     // bits written one

   // Prescaler mask: ones below the exponent, capped at 21
   // The divider runs free and is never cleared by a start, so the first
   // tick after a start lands anywhere within one tick period; this saves
   // a clear path at the cost of up to one tick of start jitter.
   always_comb begin
      logic [EXP_W-1:0] e;
      e = (s_q.exp > EXP_MAX) ? EXP_MAX : s_q.exp; // [RULE_01]
      div_mask = (DIV_W'(1) << e) - DIV_W'(1);
   end

   // Event pulses are edge detected so long levels act once
   // Without this a level held high would retrigger the timer on every
   // clock; the previous level lives in the state record.
   assign ev_now  = {RX_END, RX_BEGIN, TX_END, TX_BEGIN};
   assign ev_rise = ev_now & ~s_q.ev_prev; // [RULE_25]
   assign tick    = ((s_q.div & div_mask) == div_mask); // [RULE_01]

   // Wrap and expiry are decided on a tick at count one
   assign wrap   = s_q.running && tick && s_q.count == ONE8
                   && s_q.auto_rl; // [RULE_03]
   // A start or stop in the very cycle of the last step cancels the
   // expiry: a start retriggers before zero is reached, and a stop, the
   // software stop above all, must leave no request behind
   assign expire = s_q.running && tick && s_q.count == ONE8
                   && !s_q.auto_rl // [RULE_22]
                   && !start_ev && !stop_ev; // [RULE_09] [RULE_13]

   // Configured starts and stops
   // Enable bits gate only the edges; the command bits need none
   assign start_ev = (ev_rise[0] & s_q.tctrl[BIT_START_TXB])
                   | (ev_rise[1] & s_q.tctrl[BIT_START_TXE])
                   | wrap | s_q.start_cmd; // [RULE_04]
   assign stop_ev  = (ev_rise[2] & s_q.tctrl[BIT_STOP_RXB])
                   | (ev_rise[3] & s_q.tctrl[BIT_STOP_RXE])
                   | s_q.stop_cmd; // [RULE_06] [RULE_07]
   assign wmask = WDATA & IRQ_USED;

   // Next state
   always_comb begin
      s_d = s_q;
      s_d.ev_prev   = ev_now;
      s_d.div       = s_q.div + DIV_W'(1);
      s_d.start_cmd = 1'b0;
      s_d.stop_cmd  = 1'b0;
      s_d.send      = 1'b0;
      // Counter; the expiry only touches its own flag
      if (start_ev) begin
         // Retrigger: a running timer reloads as well
         s_d.count   = s_q.reload; // [RULE_05] [RULE_24]
         s_d.running = 1'b1; // [RULE_10]
      end else if (stop_ev) begin
         // The count is kept so software can read the elapsed time
         s_d.running = 1'b0; // [RULE_06] [RULE_10]
      end else if (s_q.running && tick && s_q.count != ZERO8) begin
         // One step per tick; the last step without reload stops
         s_d.count = s_q.count - ONE8; // [RULE_02] [RULE_12]
         if (expire)
            s_d.running = 1'b0; // [RULE_07]
      end else if (s_q.running && s_q.count == ZERO8) begin
         s_d.running = 1'b0; // Zero reload stops at once
      end
      // Register writes; reload never touches count
      // Bit 7 of an interrupt write picks set or clear, and only the
      // bits written as one move; the reserved bits stay at zero
      if (WR) begin
         unique case (ADDR)
            REG_IRQ_EN: begin
               if (WDATA[BIT_SET_SELECT])
                  s_d.irq_en = s_q.irq_en | wmask; // [RULE_23]
               else
                  s_d.irq_en = s_q.irq_en & ~wmask; // [RULE_23]
            end
            REG_IRQ_RQ: begin
               if (WDATA[BIT_SET_SELECT])
                  s_d.irq_rq = s_q.irq_rq | wmask; // [RULE_23]
               else
                  s_d.irq_rq = s_q.irq_rq & ~wmask; // [RULE_23]
            end
            REG_CONTROL: begin
               s_d.start_cmd = WDATA[BIT_START_NOW]; // [RULE_25]
               s_d.stop_cmd  = WDATA[BIT_STOP_NOW]; // [RULE_25]
            end
            REG_TIMER_CLOCK: begin
               s_d.exp     = WDATA[EXP_W-1:0];
               s_d.auto_rl = WDATA[BIT_AUTO_RELOAD];
            end
            REG_TIMER_CTRL:  s_d.tctrl  = WDATA[3:0];
            REG_RELOAD:      s_d.reload = WDATA; // [RULE_08]
            REG_SLOT_LOW:    s_d.slot_val[7:0] = WDATA;
            REG_SIG_OUT_SEL:
               s_d.slot_val[SLOT_W-1] = WDATA[BIT_SLOT_MSB]; // [RULE_20]
            REG_CODER_RATE:  s_d.coder = WDATA;
            default: ;
         endcase
      end
      // Hardware set wins over a software clear in the same cycle
      if (wrap || expire)
         s_d.irq_rq[BIT_TIMER_IRQ] = 1'b1; // [RULE_13] [RULE_22] [RULE_09]
      // Slot counter, stepped by coder clock enable
      // The interval is loaded at each restart only, so a value written
      // while slots run waits for the next restart; a zero interval
      // parks the counter and no send can follow
      if (s_q.slot_val == '0) begin
         s_d.slot_act = 1'b0; // [RULE_18]
      end else if (ev_rise[1]) begin
         s_d.slot_cnt = s_q.slot_val; // [RULE_14] [RULE_19]
         s_d.slot_act = 1'b1;
      end else if (s_q.slot_act && CODER_CLK_EN) begin
         if (s_q.slot_cnt == SLOT_W'(1)) begin
            s_d.slot_cnt = s_q.slot_val; // [RULE_16] [RULE_19]
            s_d.send     = FIFO_NOT_EMPTY; // [RULE_15]
         end else begin
            s_d.slot_cnt = s_q.slot_cnt - SLOT_W'(1); // [RULE_17]
         end
      end
      s_d.irq_out = |(s_d.irq_rq[BIT_TIMER_IRQ] &
                      s_d.irq_en[BIT_TIMER_IRQ]);
      // Read answer, one cycle after strobe
      // Unread cycles return zero, so the port shows data only in the
      // cycle after the strobe and a stale value never lingers
      s_d.rdata = ZERO8;
      if (RD) begin
         unique case (ADDR)
            REG_IRQ_EN:      s_d.rdata = s_q.irq_en;
            REG_IRQ_RQ:      s_d.rdata = s_q.irq_rq;
            REG_TIMER_VALUE: s_d.rdata = s_q.count; // [RULE_11]
            REG_SEC_STATUS:
               s_d.rdata = {s_q.running, 7'h00}; // [RULE_10]
            REG_TIMER_CLOCK:
               s_d.rdata = {2'b00, s_q.auto_rl, s_q.exp};
            REG_TIMER_CTRL:  s_d.rdata = {4'h0, s_q.tctrl};
            REG_RELOAD:      s_d.rdata = s_q.reload;
            REG_SLOT_LOW:    s_d.rdata = s_q.slot_val[7:0];
            REG_SIG_OUT_SEL:
               s_d.rdata = {s_q.slot_val[SLOT_W-1], 7'h00};
            REG_CODER_RATE:  s_d.rdata = s_q.coder;
            default:         s_d.rdata = ZERO8;
         endcase
      end
   end

   // State register
   // Synchronous reset; every field clears but the coder rate, which
   // comes up at its default rate
   always_ff @(posedge MCLK) begin
      if (RST) begin
         s_q       <= '0;
         s_q.coder <= CODER_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Every output is a flip-flop of the state record
   assign RDATA     = s_q.rdata;
   assign SLOT_SEND = s_q.send;
   assign TIMER_IRQ = s_q.irq_out;

   // Checks; every property samples on the master clock and is off
   // while reset is high, so the cleared state needs no special case

   // Software command writes on the register port
   sequence s_start_write;
      WR && ADDR == REG_CONTROL && WDATA[BIT_START_NOW];
   endsequence
   sequence s_stop_write;
      WR && ADDR == REG_CONTROL && WDATA[BIT_STOP_NOW]
         && !WDATA[BIT_START_NOW];
   endsequence
   // Last coder clock of a running slot interval
   sequence s_slot_last;
      s_q.slot_val != '0 && !ev_rise[1] && s_q.slot_act
         && CODER_CLK_EN && s_q.slot_cnt == SLOT_W'(1);
   endsequence

   // Timer counter
   a_reload_hold: assert property ( // [RULE_08]
      @(posedge MCLK) disable iff (RST)
      (WR && ADDR == REG_RELOAD && !start_ev) |=>
      (s_q.count == $past(s_q.count) ||
       s_q.count == $past(s_q.count) - ONE8 || s_q.count == ZERO8))
      else $error("reload write disturbed count");
   a_start_load: assert property ( // [RULE_05] [RULE_24]
      @(posedge MCLK) disable iff (RST)
      start_ev |=> (s_q.running && s_q.count == $past(s_q.reload)))
      else $error("start did not load reload");
   a_stop_clear: assert property ( // [RULE_06]
      @(posedge MCLK) disable iff (RST)
      (stop_ev && !start_ev) |=> !s_q.running)
      else $error("stop left timer running");
   a_tick_step: assert property ( // [RULE_02]
      @(posedge MCLK) disable iff (RST)
      (s_q.running && tick && s_q.count > ONE8 && !start_ev && !stop_ev)
      |=> (s_q.count == $past(s_q.count) - ONE8))
      else $error("tick did not step count by one");
   a_tick_hold: assert property ( // [RULE_10]
      @(posedge MCLK) disable iff (RST)
      (s_q.running && !tick && !start_ev && !stop_ev
       && s_q.count != ZERO8) |=> $stable(s_q.count))
      else $error("count moved between ticks");
   a_idle_frozen: assert property ( // [RULE_10]
      @(posedge MCLK) disable iff (RST)
      (!s_q.running && !start_ev) |=> $stable(s_q.count))
      else $error("count moved while stopped");
   a_auto_nonzero: assert property ( // [RULE_03]
      @(posedge MCLK) disable iff (RST)
      (s_q.running && s_q.auto_rl && s_q.reload != ZERO8
       && s_q.count != ZERO8) |=> (s_q.count != ZERO8))
      else $error("auto reload let count reach zero");
   a_expire_stop: assert property ( // [RULE_07]
      @(posedge MCLK) disable iff (RST)
      expire |=> (!s_q.running && s_q.count == ZERO8))
      else $error("expiry did not stop at zero");
   a_cmd_start: assert property ( // [RULE_04] [RULE_25]
      @(posedge MCLK) disable iff (RST)
      s_start_write |=> ##1 (s_q.running
                             && s_q.count == $past(s_q.reload)))
      else $error("start command not acted on");
   a_cmd_stop: assert property ( // [RULE_07] [RULE_25]
      @(posedge MCLK) disable iff (RST)
      (s_stop_write ##1 !start_ev) |=> !s_q.running)
      else $error("stop command not acted on");

   // Interrupt request and pin
   a_expiry_flag: assert property ( // [RULE_22]
      @(posedge MCLK) disable iff (RST)
      (expire || wrap) |=> s_q.irq_rq[BIT_TIMER_IRQ])
      else $error("expiry flag not set");
   a_sw_stop_quiet: assert property ( // [RULE_09]
      @(posedge MCLK) disable iff (RST)
      (s_q.stop_cmd && !start_ev && !s_q.irq_rq[BIT_TIMER_IRQ]
       && !(WR && ADDR == REG_IRQ_RQ)) |=> !s_q.irq_rq[BIT_TIMER_IRQ])
      else $error("software stop raised the flag");
   a_irq_pin: assert property ( // [RULE_13]
      @(posedge MCLK) disable iff (RST)
      TIMER_IRQ == (s_q.irq_rq[BIT_TIMER_IRQ]
                    && s_q.irq_en[BIT_TIMER_IRQ]))
      else $error("timer irq pin disagrees with flags");
   a_irq_untouched: assert property ( // [RULE_23]
      @(posedge MCLK) disable iff (RST)
      (WR && ADDR == REG_IRQ_EN) |=>
      ((s_q.irq_en & ~$past(wmask))
       == ($past(s_q.irq_en) & ~$past(wmask))))
      else $error("enable write moved unwritten bits");

   // Register read port and exponent cap
   a_read_count: assert property ( // [RULE_11]
      @(posedge MCLK) disable iff (RST)
      (RD && ADDR == REG_TIMER_VALUE) |=> (RDATA == $past(s_q.count)))
      else $error("timer value read wrong");
   a_rdata_idle: assert property ( // [RULE_11]
      @(posedge MCLK) disable iff (RST)
      !RD |=> (RDATA == ZERO8))
      else $error("read data without read strobe");
   a_exp_cap: assert property ( // [RULE_01]
      @(posedge MCLK) disable iff (RST)
      (s_q.exp > EXP_MAX) |-> (div_mask == DIV_W'(22'h1F_FFFF)))
      else $error("exponent not capped");

   // Slot interval counter
   a_no_zero_slot: assert property ( // [RULE_18]
      @(posedge MCLK) disable iff (RST)
      (s_q.slot_val == '0) |=> !s_q.send)
      else $error("send with zero slot");
   a_slot_idle: assert property ( // [RULE_18]
      @(posedge MCLK) disable iff (RST)
      (s_q.slot_val == '0) |=> !s_q.slot_act)
      else $error("slot counter active at zero interval");
   a_send_fifo: assert property ( // [RULE_15]
      @(posedge MCLK) disable iff (RST)
      s_q.send |-> $past(FIFO_NOT_EMPTY))
      else $error("send with empty fifo");
   a_slot_start: assert property ( // [RULE_14] [RULE_19]
      @(posedge MCLK) disable iff (RST)
      (s_q.slot_val != '0 && ev_rise[1]) |=>
      (s_q.slot_act && s_q.slot_cnt == $past(s_q.slot_val)))
      else $error("slot counter not started at command end");
   a_slot_restart: assert property ( // [RULE_16] [RULE_15]
      @(posedge MCLK) disable iff (RST)
      s_slot_last |=> (s_q.slot_cnt == $past(s_q.slot_val)
                       && s_q.send == $past(FIFO_NOT_EMPTY)))
      else $error("slot counter did not restart");
   a_slot_quiet: assert property ( // [RULE_17]
      @(posedge MCLK) disable iff (RST)
      (s_q.slot_act && !CODER_CLK_EN && !ev_rise[1]
       && s_q.slot_val != '0) |=> ($stable(s_q.slot_cnt) && !s_q.send))
      else $error("slot counter moved without coder clock");
endmodule : rett_timer

//--- sim/rett_events.sv
// Far-side model: coder clock and transmit/receive event lines
`timescale 1ns/1ps
module rett_events #(
   parameter int DIV = 4 // Master clocks per coder clock
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   output logic            coder_en,
   output logic [3:0]      ev
);
   int cnt; // Coder clock divider
   // Quiet lines from time zero so the timer sees no false edge
   initial begin
      ev = 4'h0;
      coder_en = 1'b0;
   end
   // One enable pulse per coder clock cycle
   always @(posedge mclk) begin
      if (rst || cnt == DIV - 1) cnt <= 0;
      else cnt <= cnt + 1;
      coder_en <= !rst && cnt == DIV - 1;
   end
   // Slot frames carry no checksum; its enable lives elsewhere
   // Event held high a few cycles; only its rising edge counts
   task automatic fire(input int n);
      @(posedge mclk);
      ev[n] <= 1'b1;
      repeat (3) @(posedge mclk);
      ev[n] <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : fire
endmodule : rett_events

//--- sim/reader_event_timer_and_slot_trigger_tb_top.sv
// Self-checking bench for the event timer and slot trigger
`timescale 1ns/1ps
module reader_event_timer_and_slot_trigger_tb_top;
   import rett_pkg::*;
   logic       mclk = 1'b0;     // 40 MHz master clock
   logic       rst = 1'b1;      // Synchronous reset
   logic [5:0] addr = 6'h00;    // Register index
   logic [7:0] wdata = 8'h00;   // Write data
   logic       wr = 1'b0;       // Write strobe
   logic       rd = 1'b0;       // Read strobe
   logic       fifo_ne = 1'b0;  // Queued data present
   logic [7:0] rdata;           // Read data
   logic       slot_send;       // Slot send pulse
   logic       timer_irq;       // Masked expiry request
   logic       coder_en;        // Coder clock enable
   logic [3:0] ev;              // Tx begin, tx end, rx begin, rx end
   logic [7:0] got;             // Last value read
   int         num_errors = 0;  // Mismatches seen
   int         num_checks = 0;  // Comparisons made
   int         n;               // Slot pulse count
   always #12.5 mclk = ~mclk;
   rett_timer i_dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .TX_BEGIN(ev[0]), .TX_END(ev[1]),
      .RX_BEGIN(ev[2]), .RX_END(ev[3]), .CODER_CLK_EN(coder_en),
      .FIFO_NOT_EMPTY(fifo_ne), .RDATA(rdata), .SLOT_SEND(slot_send),
      .TIMER_IRQ(timer_irq));
   rett_events i_evt (.mclk(mclk), .rst(rst), .coder_en(coder_en), .ev(ev));
   // One-cycle write strobe
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   // One-cycle read strobe; data stand only in the following cycle
   task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   // Compare a register read against its expected value
   task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] g;
      rd_reg(a, g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk_rd
   // Compare a single flag or condition
   task automatic chk_bit(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk_bit
   // Count slot send pulses over a fixed window
   task automatic count_sends(output int k);
      k = 0;
      repeat (200) begin
         @(posedge mclk);
         #1 if (slot_send === 1'b1) k++;
      end
   endtask : count_sends
   // Print the counts and the verdict, then stop
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   // Watchdog: tests take about 1300 cycles, allow 20000
   initial begin
      #500000;
      num_errors++;
      end_sim;
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      chk_rd(REG_SEC_STATUS, 8'h00);
      chk_rd(REG_CODER_RATE, CODER_RESET);
      chk_rd(6'h3A, 8'h00);
      // One-shot at one tick per clock
      wr_reg(REG_IRQ_EN, 8'hA0);
      wr_reg(REG_TIMER_CLOCK, 8'h00);
      wr_reg(REG_RELOAD, 8'h20);
      wr_reg(REG_CONTROL, 8'h02);
      repeat (3) @(posedge mclk);
      chk_rd(REG_SEC_STATUS, 8'h80);
      repeat (40) @(posedge mclk);
      chk_rd(REG_SEC_STATUS, 8'h00);
      chk_rd(REG_TIMER_VALUE, 8'h00);
      chk_rd(REG_IRQ_RQ, 8'h20);
      chk_bit(timer_irq, 1'b1);
      // Set and clear through the select bit, then mask
      wr_reg(REG_IRQ_RQ, 8'h20);
      chk_rd(REG_IRQ_RQ, 8'h00);
      chk_bit(timer_irq, 1'b0);
      wr_reg(REG_IRQ_RQ, 8'h81);
      wr_reg(REG_IRQ_RQ, 8'hA0);
      chk_rd(REG_IRQ_RQ, 8'h21);
      wr_reg(REG_IRQ_EN, 8'h20);
      chk_rd(REG_IRQ_EN, 8'h00);
      chk_bit(timer_irq, 1'b0);
      wr_reg(REG_IRQ_RQ, 8'h3F);
      wr_reg(REG_IRQ_EN, 8'hA0);
      // Reload rewrite while running, then software stop
      wr_reg(REG_TIMER_CLOCK, 8'h04);
      wr_reg(REG_RELOAD, 8'hF0);
      wr_reg(REG_CONTROL, 8'h02);
      wr_reg(REG_RELOAD, 8'h03);
      repeat (40) @(posedge mclk);
      wr_reg(REG_CONTROL, 8'h04);
      repeat (3) @(posedge mclk);
      rd_reg(REG_TIMER_VALUE, got);
      chk_bit(got >= 8'hEB && got <= 8'hF0, 1'b1);
      chk_rd(REG_SEC_STATUS, 8'h00);
      chk_rd(REG_IRQ_RQ, 8'h00);
      repeat (40) @(posedge mclk);
      chk_rd(REG_TIMER_VALUE, got);
      // Restart picks up the new reload value and runs out
      wr_reg(REG_CONTROL, 8'h02);
      repeat (3) @(posedge mclk);
      rd_reg(REG_TIMER_VALUE, got);
      chk_bit(got == 8'h03 || got == 8'h02, 1'b1);
      repeat (80) @(posedge mclk);
      chk_rd(REG_IRQ_RQ, 8'h20);
      wr_reg(REG_IRQ_RQ, 8'h20);
      // Start and stop together: start wins
      wr_reg(REG_RELOAD, 8'hF0);
      wr_reg(REG_CONTROL, 8'h06);
      repeat (3) @(posedge mclk);
      chk_rd(REG_SEC_STATUS, 8'h80);
      wr_reg(REG_CONTROL, 8'h04);
      // Auto reload never lets the count reach zero
      wr_reg(REG_TIMER_CLOCK, 8'h20);
      wr_reg(REG_RELOAD, 8'h03);
      wr_reg(REG_CONTROL, 8'h02);
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         rd_reg(REG_TIMER_VALUE, got);
         chk_bit(got != 8'h00 && got <= 8'h03, 1'b1);
      end
      chk_rd(REG_SEC_STATUS, 8'h80);
      chk_rd(REG_IRQ_RQ, 8'h20);
      wr_reg(REG_CONTROL, 8'h04);
      wr_reg(REG_IRQ_RQ, 8'h20);
      // Exponent above the legal top is held and capped inside
      wr_reg(REG_TIMER_CLOCK, 8'h1F);
      chk_rd(REG_TIMER_CLOCK, 8'h1F);
      // Transmit events start, receive events stop
      wr_reg(REG_TIMER_CLOCK, 8'h04);
      wr_reg(REG_RELOAD, 8'hF0);
      for (int i = 0; i < 2; i++) begin
         wr_reg(REG_TIMER_CTRL, i == 0 ? 8'h05 : 8'h0A);
         i_evt.fire(i);
         chk_rd(REG_SEC_STATUS, 8'h80);
         i_evt.fire(i + 2);
         chk_rd(REG_SEC_STATUS, 8'h00);
      end
      wr_reg(REG_TIMER_CTRL, 8'h00);
      i_evt.fire(0);
      chk_rd(REG_SEC_STATUS, 8'h00);
      chk_rd(REG_IRQ_RQ, 8'h00);
      // Slot trigger: interval 5 coder clocks, 20 master clocks
      wr_reg(REG_SLOT_LOW, 8'h05);
      fifo_ne <= 1'b1;
      i_evt.fire(1);
      count_sends(n);
      chk_bit(n >= 9 && n <= 10, 1'b1);
      fifo_ne <= 1'b0;
      count_sends(n);
      chk_bit(n == 0, 1'b1);
      wr_reg(REG_SLOT_LOW, 8'h00);
      repeat (40) @(posedge mclk);
      fifo_ne <= 1'b1;
      i_evt.fire(1);
      count_sends(n);
      chk_bit(n == 0, 1'b1);
      wr_reg(REG_SIG_OUT_SEL, 8'h80);
      chk_rd(REG_SIG_OUT_SEL, 8'h80);
      // Interval 0x101: a lost top bit would send every coder clock
      wr_reg(REG_SLOT_LOW, 8'h01);
      i_evt.fire(1);
      count_sends(n);
      chk_bit(n == 0, 1'b1);
      end_sim;
   end
endmodule : reader_event_timer_and_slot_trigger_tb_top
